/* hw/mfc_pkg.sv */
package mfc_pkg;

   // ***********************************
   // Register map
   // ***********************************
   localparam int unsigned ADDR_W      = 4;
   localparam int unsigned DATA_W      = 16;
   localparam logic [3:0]  OFS_MAC_CTL = 4'h0;   // mac_control_1
   localparam logic [3:0]  OFS_FLOW    = 4'h1;   // flow_op_code, auto_flow_enable
   localparam logic [3:0]  OFS_PTV     = 4'h2;   // pause_time_value
   localparam logic [3:0]  OFS_WMARK   = 4'h3;   // rx_watermark
   localparam logic [3:0]  OFS_STATUS  = 4'h4;   // live flow state
   localparam logic [3:0]  OFS_TIMER   = 4'h5;   // received pause count

   // ***********************************
   // Field layouts and reset values
   // ***********************************
   localparam logic [15:0] MC1_RESET    = 16'h000D;
   localparam logic [15:0] MC1_WMASK    = 16'hCF1F;   // Unimplemented bits read zero
   localparam int unsigned MC1_LOOP_BIT = 4;
   localparam int unsigned MC1_PRX_BIT  = 2;
   localparam int unsigned MC1_PALL_BIT = 1;
   localparam int unsigned FLW_AUTO_BIT = 7;
   localparam int unsigned ST_HOLD_BIT  = 0;
   localparam int unsigned ST_ACT_BIT   = 1;
   localparam int unsigned ST_JAM_BIT   = 2;
   localparam int unsigned ST_FDX_BIT   = 3;
   localparam logic [15:0] PTV_RESET    = 16'h1000;
   localparam logic [15:0] WMARK_RESET  = 16'h100F;   // Full 16, empty 15 blocks
   localparam logic [15:0] BLOCK_BYTES  = 16'h0060;   // 96-byte blocks
   localparam logic [15:0] ZERO16       = 16'h0000;

   // ***********************************
   // Flow opcodes and link constants
   // ***********************************
   localparam logic [1:0]  FOP_IDLE   = 2'h0;
   localparam logic [1:0]  FOP_SINGLE = 2'h1;
   localparam logic [1:0]  FOP_CONT   = 2'h2;
   localparam logic [1:0]  FOP_END    = 2'h3;
   localparam logic [47:0] PAUSE_DA   = 48'h0180C2000001;
   localparam logic [7:0]  JAM_BYTE   = 8'h55;

   // ***********************************
   // Timing
   // ***********************************
   localparam int unsigned CLK_MHZ       = 25;
   localparam int unsigned QUANTUM_BITS  = 512;
   localparam int unsigned RATE_100_MBPS = 100;
   localparam int unsigned RATE_10_MBPS  = 10;
   localparam int unsigned QCYC_100 = QUANTUM_BITS * CLK_MHZ / RATE_100_MBPS;
   localparam int unsigned QCYC_10  = QUANTUM_BITS * CLK_MHZ / RATE_10_MBPS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_ZERO = 2'b10
   } mfc_tx_state_t;

   // Byte threshold from a block count
   function automatic logic [15:0] mfc_thr_bytes(input logic [7:0] blocks);
      mfc_thr_bytes = 16'(16'(blocks) * BLOCK_BYTES);
   endfunction

endpackage

/* hw/mfc_tmr_if.sv */
`timescale 1ns/10ps
interface mfc_tmr_if;
   logic        load;
   logic [15:0] load_val;
   logic        speed_100;
   logic        busy;
   logic [15:0] count;

   modport ctl (output load, output load_val, output speed_100, input busy, input count);
   modport tmr (input load, input load_val, input speed_100, output busy, output count);
endinterface

/* hw/mfc_pause_timer.sv */
`timescale 1ns/10ps
module mfc_pause_timer
   import mfc_pkg::*;
#(
   parameter int unsigned QC100 = QCYC_100,
   parameter int unsigned QC10  = QCYC_10
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   mfc_tmr_if.tmr   t
);

   // ***********************************
   // Parameter check
   // ***********************************
   if (QC100 < 1 || QC10 < 1 || QC100 > 2048 || QC10 > 2048) begin : g_bad
      $error("mfc_pause_timer: quantum cycle count out of range");
   end

   localparam logic [10:0] LIM100 = 11'(QC100 - 1);
   localparam logic [10:0] LIM10  = 11'(QC10 - 1);

   logic [10:0] pre;
   logic [15:0] count;
   logic [10:0] lim;

   assign lim     = t.speed_100 ? LIM100 : LIM10;
   assign t.count = count;
   assign t.busy  = (count != ZERO16);

   // Quantum prescaler and down counter
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         pre   <= 11'h000;
         count <= 16'h0000;
      end else if (t.load) begin                   // [R21]
         pre   <= 11'h000;
         count <= t.load_val;
      end else if (count != ZERO16) begin
         if (pre >= lim) begin                     // [R24]
            pre   <= 11'h000;
            count <= 16'(count - 16'h0001);
         end else begin
            pre <= 11'(pre + 11'h001);
         end
      end
   end

   a_load_takes: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      t.load |=> count == $past(t.load_val)) else $error("timer load lost"); // [R21]
   a_quantum_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (!t.load && count != ZERO16 && pre == lim) |=> count == $past(count) - 16'h0001)
      else $error("timer did not step at quantum end"); // [R24]

endmodule

/* hw/mfc_flow_ctrl.sv */
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// Overview of operation
// (R1) Received pause loads timer, holds transmission
// (R2) Pass-all clear: pause frames consumed internally
// (R3) Pass-all set: store frames, ignore pause
// (R4) Sent pause carries pause_time_value, 512-bit quanta
// (R5) Manual control unless auto_flow_enable set
// (R6) Opcode 01: one pause, then idle
// (R7) Opcode 10: periodic pause until 11
// (R8) Opcode 11: zero-time pause, then idle
// (R9) Half duplex: 10 starts jamming, 00 stops
// (R10) Auto: start above full, stop below empty
// (R11) Full high byte, empty low byte
// (R12) Auto drives opcode; reads 10 or 00
// (R13) Software keeps empty below full
// (R14) Watermark defaults 16 and 15 blocks
// (R15) Software programs pause time before enabling
// (R16) Software advertises pause 01 with autonegotiation
// (R17) pause_rx_enable clear ignores received pauses
// (R18) Pass-all selects drop or store control frames
// (R19) mac_loopback loops transmit back inside MAC
// (R20) Software writes reserved bits as specified
// (R21) New pause restarts timer; zero ends it
// (R22) Pause frames use reserved multicast address
// (R23) Back pressure sends 55h preamble pattern
// (R24) Timer ticks per 512 bit times
// (R25) Refresh pause before remote time expires
module mfc_flow_ctrl
   import mfc_pkg::*;
#(
   parameter logic [15:0] PTV_DEFAULT = PTV_RESET
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        full_duplex_i,
   input  wire logic        speed_100_i,
   input  wire logic [15:0] rx_used_bytes_i,
   input  wire logic        rx_pause_valid_i,
   input  wire logic [15:0] rx_pause_time_i,
   input  wire logic        tx_request_i,
   output logic             tx_enable_o,
   output logic             pause_send_o,
   output logic      [15:0] pause_time_o,
   output logic      [47:0] pause_da_o,
   input  wire logic        pause_done_i,
   output logic             jam_o,
   output logic      [7:0]  jam_pattern_o,
   output logic             rx_ctrl_keep_o,
   output logic             mac_loopback_o
);

   // ***********************************
   // Declarations
   // ***********************************
   logic [15:0]   mac_ctl;
   logic [1:0]    fop;
   logic          auto_en;
   logic [15:0]   ptv;
   logic [15:0]   wmark;
   logic          auto_act;
   logic          auto_stop;
   mfc_tx_state_t state;
   logic          hold;
   logic          fc_on;
   logic          wr_flow;
   logic          pass_all;
   logic          prx_en;
   logic          rx_load;
   logic          want_pause;
   logic          want_zero;
   logic          send_ok;
   logic [15:0]   refresh_val;
   logic [15:0]   full_thr;
   logic [15:0]   empty_thr;

   mfc_tmr_if rx_t ();
   mfc_tmr_if rf_t ();

   // ***********************************
   // Received pause and refresh timers
   // ***********************************
   mfc_pause_timer #(
      .QC100 (QCYC_100),
      .QC10  (QCYC_10)
   ) u_rx_timer (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .t          (rx_t)
   );

   mfc_pause_timer #(
      .QC100 (QCYC_100),
      .QC10  (QCYC_10)
   ) u_refresh_timer (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .t          (rf_t)
   );

   // Control bit decode
   assign pass_all = mac_ctl[MC1_PALL_BIT];
   assign prx_en   = mac_ctl[MC1_PRX_BIT];
   assign rx_load  = rx_pause_valid_i && prx_en && !pass_all;   // [R2] [R3] [R17]
   assign hold     = rx_t.busy && prx_en && !pass_all;          // [R1] [R3]
   assign wr_flow  = reg_wr_i && reg_addr_i == OFS_FLOW;

   // Timer controls
   assign rx_t.load      = rx_load;                              // [R21]
   assign rx_t.load_val  = rx_pause_time_i;
   assign rx_t.speed_100 = speed_100_i;
   assign refresh_val    = (ptv > 16'h0001) ? {1'b0, ptv[15:1]} : 16'h0001;
   assign rf_t.load      = state == ST_SEND && pause_done_i;     // [R25]
   assign rf_t.load_val  = refresh_val;
   assign rf_t.speed_100 = speed_100_i;

   // ***********************************
   // Register writes
   // ***********************************
   // MAC control bits
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         mac_ctl <= MC1_RESET;
      end else if (reg_wr_i && reg_addr_i == OFS_MAC_CTL) begin
         mac_ctl <= reg_wdata_i & MC1_WMASK;                     // [R20]
      end
   end

   // Pause time and watermarks
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ptv   <= PTV_DEFAULT;
         wmark <= WMARK_RESET;                                   // [R14]
      end else if (reg_wr_i) begin
         if (reg_addr_i == OFS_PTV) begin
            ptv <= reg_wdata_i;
         end
         if (reg_addr_i == OFS_WMARK) begin
            wmark <= reg_wdata_i;
         end
      end
   end

   // Auto enable; manual after reset
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         auto_en <= 1'b0;                                        // [R5]
      end else if (wr_flow) begin
         auto_en <= reg_wdata_i[FLW_AUTO_BIT];
      end
   end

   // Manual opcode; a software write beats the self clear
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         fop <= FOP_IDLE;
      end else if (wr_flow && !reg_wdata_i[FLW_AUTO_BIT] && !auto_en) begin
         fop <= reg_wdata_i[1:0];                                // [R5]
      end else if (auto_en) begin
         fop <= FOP_IDLE;
      end else if (state != ST_IDLE && pause_done_i && fop != FOP_CONT) begin
         fop <= FOP_IDLE;                                        // [R6] [R8]
      end
   end

   // ***********************************
   // Automatic watermarks
   // ***********************************
   assign full_thr  = mfc_thr_bytes(wmark[15:8]);                // [R11]
   assign empty_thr = mfc_thr_bytes(wmark[7:0]);                 // [R11]

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         auto_act <= 1'b0;
      end else if (!auto_en) begin
         auto_act <= 1'b0;
      end else if (rx_used_bytes_i > full_thr) begin
         auto_act <= 1'b1;                                       // [R10]
      end else if (rx_used_bytes_i < empty_thr) begin
         auto_act <= 1'b0;                                       // [R10]
      end
   end

   // Zero-time frame owed when auto pause ends
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         auto_stop <= 1'b0;
      end else if (auto_act && auto_en && rx_used_bytes_i < empty_thr && full_duplex_i) begin
         auto_stop <= 1'b1;
      end else if (state == ST_ZERO && pause_done_i) begin
         auto_stop <= 1'b0;
      end
   end

   // ***********************************
   // Pause frame sender
   // ***********************************
   assign fc_on      = auto_en ? auto_act : (fop != FOP_IDLE);
   assign want_zero  = (!auto_en && fop == FOP_END) || auto_stop;              // [R8]
   assign want_pause = (!auto_en && fop == FOP_SINGLE)
                     || ((auto_en ? auto_act : fop == FOP_CONT) && !rf_t.busy); // [R7] [R25]
   assign send_ok    = full_duplex_i && state == ST_IDLE;

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         state        <= ST_IDLE;
         pause_send_o <= 1'b0;
         pause_time_o <= ZERO16;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (send_ok && want_zero) begin
                  state        <= ST_ZERO;
                  pause_send_o <= 1'b1;
                  pause_time_o <= ZERO16;                        // [R8]
               end else if (send_ok && want_pause) begin
                  state        <= ST_SEND;
                  pause_send_o <= 1'b1;
                  pause_time_o <= ptv;                           // [R4]
               end
            end
            ST_SEND, ST_ZERO: begin
               if (pause_done_i) begin
                  state        <= ST_IDLE;
                  pause_send_o <= 1'b0;
               end
            end
            default: begin
               state        <= ST_IDLE;
               pause_send_o <= 1'b0;
            end
         endcase
      end
   end

   // ***********************************
   // MAC side outputs
   // ***********************************
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         tx_enable_o    <= 1'b0;
         jam_o          <= 1'b0;
         jam_pattern_o  <= JAM_BYTE;
         pause_da_o     <= PAUSE_DA;
         rx_ctrl_keep_o <= 1'b0;
         mac_loopback_o <= 1'b0;
      end else begin
         tx_enable_o    <= tx_request_i && !hold;                        // [R1]
         jam_o          <= fc_on && !full_duplex_i && !tx_request_i;     // [R9]
         jam_pattern_o  <= JAM_BYTE;                                     // [R23]
         pause_da_o     <= PAUSE_DA;                                     // [R22]
         rx_ctrl_keep_o <= pass_all;                                     // [R18]
         mac_loopback_o <= mac_ctl[MC1_LOOP_BIT];                        // [R19]
      end
   end

   // ***********************************
   // Register reads
   // ***********************************
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= ZERO16;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_MAC_CTL: reg_rdata_o <= mac_ctl;
            OFS_FLOW:    reg_rdata_o <= {8'h00, auto_en, 5'h00,
                                         auto_en ? (auto_act ? FOP_CONT : FOP_IDLE) : fop}; // [R12]
            OFS_PTV:     reg_rdata_o <= ptv;
            OFS_WMARK:   reg_rdata_o <= wmark;
            OFS_STATUS:  reg_rdata_o <= {12'h000, full_duplex_i, jam_o, fc_on, hold};
            OFS_TIMER:   reg_rdata_o <= rx_t.count;
            default:     reg_rdata_o <= ZERO16;
         endcase
      end else begin
         reg_rdata_o <= ZERO16;
      end
   end

   // ***********************************
   // Checks
   // ***********************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_frame_sent;
      state == ST_SEND && pause_done_i;
   endsequence

   a_hold_blocks_tx: assert property (hold |=> !tx_enable_o)   // [R1]
      else $error("transmit enabled while paused");
   a_pass_all_frames_no_pause: assert property (pass_all |=> tx_enable_o == $past(tx_request_i)) // [R3]
      else $error("pause honoured with pass-all set");
   a_rxpause_off: assert property (!prx_en |=> tx_enable_o == $past(tx_request_i)) // [R17]
      else $error("pause honoured while reception disabled");
   a_pause_value: assert property (state == ST_SEND |-> pause_time_o == ptv || $changed(ptv)
                                   || $past(state) == ST_SEND) // [R4]
      else $error("pause frame timer field wrong");
   a_end_zero: assert property (state == ST_ZERO |-> pause_time_o == ZERO16) // [R8]
      else $error("end frame carries nonzero time");
   a_single_idle: assert property (s_frame_sent and (fop == FOP_SINGLE && !auto_en && !wr_flow)
                                   |=> fop == FOP_IDLE) // [R6]
      else $error("single pause opcode not cleared");
   a_cont_stays: assert property (s_frame_sent and (fop == FOP_CONT && !wr_flow && !auto_en)
                                  |=> fop == FOP_CONT ##0 rf_t.busy) // [R7]
      else $error("continuous pause stopped or refresh not loaded");
   a_auto_start: assert property (auto_en && !wr_flow && rx_used_bytes_i > full_thr |=> auto_act) // [R10]
      else $error("auto flow did not start above full mark");
   a_half_jam: assert property (fc_on && !full_duplex_i && !tx_request_i |=> jam_o) // [R9]
      else $error("no jam in half duplex");
   a_loop_follows: assert property (##1 mac_loopback_o == $past(mac_ctl[MC1_LOOP_BIT])) // [R19]
      else $error("loopback output mismatch");

endmodule

/* tb/mfc_pause_peer.sv */
`timescale 1ns/10ps
module mfc_pause_peer (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       pause_send_i,
   input  wire logic [7:0] delay_i,
   output logic            pause_done_o
);
   logic [7:0] wait_cnt;

   // ***********************************
   // Transmit path of the remote-facing MAC
   // ***********************************
   // Finish a requested pause frame delay_i + 1 cycles after the request, one pulse per frame
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         wait_cnt     <= 8'h00;
         pause_done_o <= 1'b0;
      end else if (pause_send_i && !pause_done_o) begin
         wait_cnt     <= (wait_cnt == delay_i) ? 8'h00 : wait_cnt + 8'h01;
         pause_done_o <= (wait_cnt == delay_i);
      end else begin
         wait_cnt     <= 8'h00;   // Request dropping after done
         pause_done_o <= 1'b0;
      end
   end
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import mfc_pkg::*;
   logic        core_clk_i;
   logic        reset_n_i;
   logic [3:0]  reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [15:0] reg_rdata_o;
   logic        full_duplex_i;
   logic        speed_100_i;
   logic [15:0] rx_used_bytes_i;
   logic        rx_pause_valid_i;
   logic [15:0] rx_pause_time_i;
   logic        tx_request_i;
   logic        tx_enable_o;
   logic        pause_send_o;
   logic [15:0] pause_time_o;
   logic [47:0] pause_da_o;
   logic        pause_done_i;
   logic        jam_o;
   logic [7:0]  jam_pattern_o;
   logic        rx_ctrl_keep_o;
   logic        mac_loopback_o;
   logic [7:0]  peer_delay;
   logic [15:0] exp_rd[$];
   logic [15:0] exp_pause[$];
   logic        rd_pend;
   logic        send_prev;
   logic [15:0] ptv;
   logic [15:0] rxt;
   int          miscompares;
   int          num_checks;
   int          n;
   int          len;
   int          exp_len;
   localparam logic [47:0] NO_NOTE = 48'hFFFFFFFFFFFF;   // Never matches a 16-bit result

   mfc_flow_ctrl i_mfc_flow_ctrl (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .full_duplex_i, .speed_100_i, .rx_used_bytes_i, .rx_pause_valid_i,
      .rx_pause_time_i, .tx_request_i, .tx_enable_o, .pause_send_o, .pause_time_o, .pause_da_o,
      .pause_done_i, .jam_o, .jam_pattern_o, .rx_ctrl_keep_o, .mac_loopback_o);

   mfc_pause_peer i_mfc_pause_peer (.core_clk_i, .reset_n_i, .pause_send_i(pause_send_o),
      .delay_i(peer_delay), .pause_done_o(pause_done_i));

   // Clock
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // ***********************************
   // Helpers
   // ***********************************
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (miscompares == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic settle(input int k);
      repeat (k) @(negedge core_clk_i);
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      exp_rd.push_back(e);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
   endtask

   task automatic rx_pause(input logic [15:0] t);
      @(posedge core_clk_i);
      rx_pause_valid_i <= 1'b1;
      rx_pause_time_i  <= t;
      @(posedge core_clk_i);
      rx_pause_valid_i <= 1'b0;
   endtask

   // Bounded waits: transmit release, and noted results seen down to qlen pause notes
   task automatic wait_tx(output int cnt);
      for (cnt = 0; tx_enable_o !== 1'b1; cnt++) begin
         if (cnt == 5000) begin
            miscompares++;
            complete_run();
         end
         @(negedge core_clk_i);
      end
   endtask

   task automatic drain(input int qlen);
      for (int i = 0; exp_pause.size() > qlen || exp_rd.size() > 0 || pause_send_o !== 1'b0; i++) begin
         if (i == 3000) begin
            miscompares++;
            complete_run();
         end
         @(negedge core_clk_i);
      end
   endtask

   // Monitor: compare each read word and each pause frame with the oldest note
   always @(negedge core_clk_i) begin
      if (rd_pend) begin
         check("reg_rdata_o", 48'(reg_rdata_o), exp_rd.size() ? 48'(exp_rd.pop_front()) : NO_NOTE);
      end
      if (pause_send_o === 1'b1 && send_prev !== 1'b1) begin
         check("pause_time_o", 48'(pause_time_o), exp_pause.size() ? 48'(exp_pause.pop_front()) : NO_NOTE);
         check("pause_da_o", pause_da_o, PAUSE_DA);
      end
      rd_pend   = reg_rd_i;
      send_prev = pause_send_o;
   end

   // ***********************************
   // Main sequence
   // ***********************************
   initial begin
      void'($urandom(32'h29d1));
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, rx_used_bytes_i} = '0;
      {rx_pause_valid_i, rx_pause_time_i, peer_delay, reset_n_i} = '0;
      {full_duplex_i, speed_100_i, tx_request_i} = 3'b111;
      {miscompares, num_checks, rd_pend, send_prev} = '0;
      ptv = 16'($urandom_range(7, 2));
      rxt = 16'($urandom_range(3, 1));
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      // Reset values, unmapped index, write masking
      reg_rd(OFS_MAC_CTL, 16'h000D);
      reg_rd(OFS_WMARK, 16'h100F);
      reg_rd(OFS_FLOW, 16'h0000);
      reg_rd(4'h6, 16'h0000);
      check("rx_ctrl_keep_o", 48'(rx_ctrl_keep_o), 48'h0);
      reg_wr(OFS_MAC_CTL, 16'h30FF);
      reg_rd(OFS_MAC_CTL, 16'h001F);
      check("mac_loopback_o", 48'(mac_loopback_o), 48'h1);
      check("rx_ctrl_keep_o", 48'(rx_ctrl_keep_o), 48'h1);
      // Received pause ignored: receive disabled, then pass-all
      for (n = 0; n < 2; n++) begin
         reg_wr(OFS_MAC_CTL, (n == 0) ? 16'h0009 : 16'h000F);
         rx_pause(16'h0003);
         settle(4);
         check("tx_enable_o", 48'(tx_enable_o), 48'h1);
      end
      reg_wr(OFS_MAC_CTL, 16'h000D);
      settle(2);
      check("mac_loopback_o", 48'(mac_loopback_o), 48'h0);
      // Received pause hold length at both speeds
      for (n = 0; n < 2; n++) begin
         @(posedge core_clk_i);
         speed_100_i <= (n == 1);
         rx_pause(rxt);
         settle(3);
         check("tx_enable_o", 48'(tx_enable_o), 48'h0);
         wait_tx(len);
         exp_len = int'(rxt) * ((n == 1) ? QCYC_100 : QCYC_10);
         check("hold_in_range", 48'(len + 8 > exp_len && len < exp_len + 8), 48'h1);
      end
      // New pause of zero ends a running hold
      rx_pause(16'h0005);
      settle(10);
      reg_rd(OFS_TIMER, 16'h0005);
      rx_pause(16'h0000);
      settle(4);
      check("tx_enable_o", 48'(tx_enable_o), 48'h1);
      // Manual single, end and continuous pause, slow and prompt partner
      peer_delay <= 8'd20;
      reg_wr(OFS_PTV, ptv);
      exp_pause.push_back(ptv);
      reg_wr(OFS_FLOW, {14'h0, FOP_SINGLE});
      drain(0);
      reg_rd(OFS_FLOW, 16'h0000);
      peer_delay <= 8'd0;
      exp_pause.push_back(16'h0000);
      reg_wr(OFS_FLOW, {14'h0, FOP_END});
      drain(0);
      reg_rd(OFS_FLOW, 16'h0000);
      exp_pause.push_back(ptv);
      exp_pause.push_back(ptv);
      reg_wr(OFS_FLOW, {14'h0, FOP_CONT});
      drain(1);
      drain(0);
      exp_pause.push_back(16'h0000);
      reg_wr(OFS_FLOW, {14'h0, FOP_END});
      drain(0);
      reg_rd(OFS_FLOW, 16'h0000);
      // Half duplex back pressure
      @(posedge core_clk_i);
      full_duplex_i <= 1'b0;
      tx_request_i  <= 1'b0;
      reg_wr(OFS_FLOW, {14'h0, FOP_CONT});
      settle(3);
      check("jam_o", 48'(jam_o), 48'h1);
      check("jam_pattern_o", 48'(jam_pattern_o), 48'h55);
      reg_rd(OFS_STATUS, 16'h0006);
      reg_wr(OFS_FLOW, 16'h0000);
      settle(3);
      check("jam_o", 48'(jam_o), 48'h0);
      @(posedge core_clk_i);
      full_duplex_i <= 1'b1;
      tx_request_i  <= 1'b1;
      // Automatic mode with watermark boundaries
      reg_wr(OFS_WMARK, 16'h0302);
      reg_wr(OFS_FLOW, 16'h0080);
      @(posedge core_clk_i);
      rx_used_bytes_i <= 16'd288;
      settle(4);
      reg_rd(OFS_FLOW, 16'h0080);
      exp_pause.push_back(ptv);
      @(posedge core_clk_i);
      rx_used_bytes_i <= 16'd289;
      drain(0);
      reg_rd(OFS_FLOW, 16'h0082);
      reg_wr(OFS_FLOW, 16'h0081);
      reg_rd(OFS_FLOW, 16'h0082);
      @(posedge core_clk_i);
      rx_used_bytes_i <= 16'd192;
      settle(4);
      reg_rd(OFS_FLOW, 16'h0082);
      exp_pause.push_back(16'h0000);
      @(posedge core_clk_i);
      rx_used_bytes_i <= 16'd191;
      drain(0);
      reg_rd(OFS_FLOW, 16'h0080);
      drain(0);
      complete_run();
   end
endmodule
